// ===== src/pin_function_pkg.sv
package pin_function_pkg;
  localparam int NPIN  = 14;
  localparam int NFUNC = 33;
  localparam int NIRQ  = 4;

  // pin slots
  localparam logic [3:0] PIN_A2 = 4'h0;
  localparam logic [3:0] PIN_A3 = 4'h1;
  localparam logic [3:0] PIN_B0 = 4'h2;
  localparam logic [3:0] PIN_B1 = 4'h3;
  localparam logic [3:0] PIN_B2 = 4'h4;
  localparam logic [3:0] PIN_B3 = 4'h5;
  localparam logic [3:0] PIN_B4 = 4'h6;
  localparam logic [3:0] PIN_B5 = 4'h7;
  localparam logic [3:0] PIN_B6 = 4'h8;
  localparam logic [3:0] PIN_B7 = 4'h9;
  localparam logic [3:0] PIN_D3 = 4'ha;
  localparam logic [3:0] PIN_D4 = 4'hb;
  localparam logic [3:0] PIN_D5 = 4'hc;
  localparam logic [3:0] PIN_D6 = 4'hd;
  localparam logic [3:0] REG_NONE = 4'hf;

  // register indexes; byte address is four times the index
  localparam logic [31:0] IDX_PORT_A_PIN2 = 32'h0008c192;
  localparam logic [31:0] IDX_PORT_A_PIN3 = 32'h0008c193;
  localparam logic [31:0] IDX_PORT_B_PIN0 = 32'h0008c198;
  localparam logic [31:0] IDX_PORT_B_PIN1 = 32'h0008c199;
  localparam logic [31:0] IDX_PORT_B_PIN2 = 32'h0008c19a;
  localparam logic [31:0] IDX_PORT_B_PIN3 = 32'h0008c19b;
  localparam logic [31:0] IDX_PORT_B_PIN4 = 32'h0008c19c;
  localparam logic [31:0] IDX_PORT_B_PIN5 = 32'h0008c19d;
  localparam logic [31:0] IDX_PORT_B_PIN6 = 32'h0008c19e;
  localparam logic [31:0] IDX_PORT_B_PIN7 = 32'h0008c19f;
  localparam logic [31:0] IDX_PORT_D_PIN3 = 32'h0008c1ab;
  localparam logic [31:0] IDX_PORT_D_PIN4 = 32'h0008c1ac;
  localparam logic [31:0] IDX_PORT_D_PIN5 = 32'h0008c1ad;
  localparam logic [31:0] IDX_PORT_D_PIN6 = 32'h0008c1ae;
  localparam logic [NPIN-1:0][31:0] REG_INDEX = {
    IDX_PORT_D_PIN6, IDX_PORT_D_PIN5, IDX_PORT_D_PIN4, IDX_PORT_D_PIN3,
    IDX_PORT_B_PIN7, IDX_PORT_B_PIN6, IDX_PORT_B_PIN5, IDX_PORT_B_PIN4,
    IDX_PORT_B_PIN3, IDX_PORT_B_PIN2, IDX_PORT_B_PIN1, IDX_PORT_B_PIN0,
    IDX_PORT_A_PIN3, IDX_PORT_A_PIN2};

  // register fields and reset values
  localparam int         PSEL_LSB   = 0;
  localparam int         PSEL_MSB   = 4;
  localparam int         IRQ_INPUT_ENABLE_BIT   = 6;
  localparam logic [4:0] PSEL_RESET = 5'h00;
  localparam logic       IRQ_INPUT_ENABLE_RESET = 1'b0;

  // selection codes
  localparam logic [4:0] SEL_HIZ       = 5'h00;
  localparam logic [4:0] SEL_TIMER     = 5'h01;
  localparam logic [4:0] SEL_EXT_CLOCK = 5'h02;
  localparam logic [4:0] SEL_TIMER_ALT = 5'h03;
  localparam logic [4:0] SEL_CONTROL   = 5'h07;
  localparam logic [4:0] SEL_ADC       = 5'h09;
  localparam logic [4:0] SEL_SERIAL_A  = 5'h0a;
  localparam logic [4:0] SEL_SERIAL_B  = 5'h0b;
  localparam logic [4:0] SEL_SERIAL_C  = 5'h0c;
  localparam logic [4:0] SEL_I2C       = 5'h0f;

  // peripheral function slots
  localparam logic [5:0] F_TIMER0_IO_A = 6'h00;
  localparam logic [5:0] F_TIMER0_IO_B = 6'h01;
  localparam logic [5:0] F_TIMER0_IO_C = 6'h02;
  localparam logic [5:0] F_TIMER0_IO_D = 6'h03;
  localparam logic [5:0] F_TIMER1_IO_A = 6'h04;
  localparam logic [5:0] F_TIMER1_IO_B = 6'h05;
  localparam logic [5:0] F_TIMER2_IO_A = 6'h06;
  localparam logic [5:0] F_TIMER2_IO_B = 6'h07;
  localparam logic [5:0] F_TIMER3_IO_A = 6'h08;
  localparam logic [5:0] F_TIMER3_IO_C = 6'h09;
  localparam logic [5:0] F_TIMER5_CAPTURE_W = 6'h0a;
  localparam logic [5:0] F_TIMER_EXT_CLOCK_A = 6'h0b;
  localparam logic [5:0] F_TIMER_EXT_CLOCK_B = 6'h0c;
  localparam logic [5:0] F_TIMER_EXT_CLOCK_C = 6'h0d;
  localparam logic [5:0] F_TIMER_EXT_CLOCK_D = 6'h0e;
  localparam logic [5:0] F_CLOCK_ACCURACY_REFERENCE_IN = 6'h0f;
  localparam logic [5:0] F_OUTPUT_DISABLE_REQUEST_8 = 6'h10;
  localparam logic [5:0] F_ADC_SAMPLING_MONITOR = 6'h11;
  localparam logic [5:0] F_ADC_EXTERNAL_TRIGGER = 6'h12;
  localparam logic [5:0] F_ADC_CONVERSION_STATUS = 6'h13;
  localparam logic [5:0] F_SERIAL5_FLOW = 6'h14;
  localparam logic [5:0] F_SERIAL5_RECEIVE = 6'h15;
  localparam logic [5:0] F_SERIAL5_TRANSMIT = 6'h16;
  localparam logic [5:0] F_SERIAL5_CLOCK = 6'h17;
  localparam logic [5:0] F_SERIAL1_TRANSMIT = 6'h18;
  localparam logic [5:0] F_SERIAL1_RECEIVE = 6'h19;
  localparam logic [5:0] F_SERIAL1_CLOCK = 6'h1a;
  localparam logic [5:0] F_SERIAL1_FLOW = 6'h1b;
  localparam logic [5:0] F_SERIAL12_FLOW = 6'h1c;
  localparam logic [5:0] F_SERIAL12_TRANSMIT = 6'h1d;
  localparam logic [5:0] F_SERIAL12_CLOCK = 6'h1e;
  localparam logic [5:0] F_I2C0_CLOCK_LINE = 6'h1f;
  localparam logic [5:0] F_I2C0_DATA_LINE = 6'h20;
  localparam logic [5:0] F_NONE = 6'h3f;

  // interrupt request outputs, vector bit per line
  localparam int IRQ2_BIT = 0;
  localparam int IRQ3_BIT = 1;
  localparam int IRQ4_BIT = 2;
  localparam int IRQ5_BIT = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic [NPIN-1:0][4:0] psel;
    logic [NPIN-1:0]      irq_input_enable;
    logic                 aw_held;
    logic [31:0]          awaddr;
    logic                 w_held;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    axi_rsp_s             rsp;
    logic [NPIN-1:0]      pin_out;
    logic [NPIN-1:0]      pin_oe;
    logic [NFUNC-1:0]     func_i;
    logic [NIRQ-1:0]      irq;
  } state_s;
endpackage : pin_function_pkg

// ===== src/port_pin_function_selector.sv
`timescale 1ns/1ps
module port_pin_function_selector
  import pin_function_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire axi_req_s         axi_req,
  output axi_rsp_s              axi_rsp,
  input  wire logic [NPIN-1:0]  pin_in,
  output logic      [NPIN-1:0]  pin_out,
  output logic      [NPIN-1:0]  pin_oe,
  input  wire logic [NFUNC-1:0] func_o,
  input  wire logic [NFUNC-1:0] func_oe,
  output logic      [NFUNC-1:0] func_i,
  output logic      [NIRQ-1:0]  external_interrupt_request
);

  state_s st;
  state_s next_st;

  // the checks run on the bus clock and stay quiet while reset is held
  default clocking bus_clock @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // word address match; misaligned or foreign addresses give REG_NONE
  function automatic logic [3:0] reg_lookup(input logic [31:0] addr);
    logic [3:0] hit;
    hit = REG_NONE;
    for (int i = 0; i < NPIN; i++) begin
      if (addr == {REG_INDEX[i][29:0], 2'b00}) begin
        hit = 4'(i);
      end
    end
    return hit;
  endfunction : reg_lookup

  // selection table; unlisted codes map to F_NONE so the pin stays idle
  function automatic logic [5:0] route(input logic [3:0] pin, input logic [4:0] code);
    logic [5:0] f;
    f = F_NONE;
    case (pin)
      PIN_A2: begin
        if (code == SEL_TIMER) f = F_TIMER1_IO_A;
        else if (code == SEL_TIMER_ALT) f = F_TIMER2_IO_B;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_FLOW;
      end
      PIN_A3: begin
        if (code == SEL_TIMER) f = F_TIMER1_IO_B;
        else if (code == SEL_TIMER_ALT) f = F_TIMER2_IO_A;
        else if (code == SEL_SERIAL_C) f = F_SERIAL12_FLOW;
      end
      PIN_B0: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_D;
        else if (code == SEL_EXT_CLOCK) f = F_TIMER_EXT_CLOCK_B;
        else if (code == SEL_TIMER_ALT) f = F_TIMER2_IO_A;
        else if (code == SEL_SERIAL_C) f = F_SERIAL12_TRANSMIT;
      end
      PIN_B1: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_C;
        else if (code == SEL_EXT_CLOCK) f = F_TIMER_EXT_CLOCK_A;
        else if (code == SEL_TIMER_ALT) f = F_TIMER5_CAPTURE_W;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_RECEIVE;
        else if (code == SEL_I2C) f = F_I2C0_CLOCK_LINE;
      end
      PIN_B2: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_B;
        else if (code == SEL_EXT_CLOCK) f = F_TIMER_EXT_CLOCK_C;
        else if (code == SEL_ADC) f = F_ADC_SAMPLING_MONITOR;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_TRANSMIT;
        else if (code == SEL_I2C) f = F_I2C0_DATA_LINE;
      end
      PIN_B3: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_A;
        else if (code == SEL_CONTROL) f = F_CLOCK_ACCURACY_REFERENCE_IN;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_CLOCK;
        else if (code == SEL_SERIAL_C) f = F_SERIAL12_CLOCK;
      end
      PIN_B4: begin
        if (code == SEL_CONTROL) f = F_OUTPUT_DISABLE_REQUEST_8;
      end
      PIN_B5: begin
        if (code == SEL_ADC) f = F_ADC_EXTERNAL_TRIGGER;
      end
      PIN_B6: begin
        if (code == SEL_TIMER) f = F_TIMER1_IO_B;
        else if (code == SEL_TIMER_ALT) f = F_TIMER3_IO_A;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_TRANSMIT;
        else if (code == SEL_SERIAL_B) f = F_SERIAL1_TRANSMIT;
      end
      PIN_B7: begin
        if (code == SEL_TIMER) f = F_TIMER3_IO_C;
        else if (code == SEL_EXT_CLOCK) f = F_TIMER_EXT_CLOCK_D;
        else if (code == SEL_SERIAL_A) f = F_SERIAL5_RECEIVE;
        else if (code == SEL_SERIAL_B) f = F_SERIAL1_RECEIVE;
      end
      PIN_D3: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_A;
        else if (code == SEL_SERIAL_A) f = F_SERIAL1_TRANSMIT;
      end
      PIN_D4: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_B;
        else if (code == SEL_SERIAL_A) f = F_SERIAL1_CLOCK;
      end
      PIN_D5: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_C;
        else if (code == SEL_SERIAL_A) f = F_SERIAL1_RECEIVE;
      end
      PIN_D6: begin
        if (code == SEL_TIMER) f = F_TIMER0_IO_D;
        else if (code == SEL_ADC) f = F_ADC_CONVERSION_STATUS;
        else if (code == SEL_SERIAL_A) f = F_SERIAL1_FLOW;
      end
      default: f = F_NONE;
    endcase
    return f;
  endfunction : route

  logic [3:0]      wr_reg;
  logic [3:0]      rd_reg;
  logic            do_write;
  logic [NPIN-1:0] ien;

  assign wr_reg   = reg_lookup(st.awaddr);
  assign rd_reg   = reg_lookup(axi_req.araddr);
  assign do_write = st.aw_held && st.w_held && !st.rsp.bvalid;
  assign ien      = st.irq_input_enable & pin_in;

  // next state: bus slave, register file, routing and interrupt steering
  always_comb begin
    logic [5:0] f;
    f       = F_NONE;
    next_st = st;

    // write address and data are caught independently, in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_held     = 1'b1;
      next_st.awaddr      = axi_req.awaddr;
      next_st.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_held     = 1'b1;
      next_st.wdata      = axi_req.wdata;
      next_st.wstrb      = axi_req.wstrb;
      next_st.rsp.wready = 1'b0;
    end
    if (do_write) begin
      next_st.aw_held   = 1'b0;
      next_st.w_held    = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      // only the addressed register changes, and only with its lane strobed
      if (wr_reg != REG_NONE && st.wstrb[0]) begin
        next_st.psel[wr_reg] = st.wdata[PSEL_MSB:PSEL_LSB];
        next_st.irq_input_enable[wr_reg] = st.wdata[IRQ_INPUT_ENABLE_BIT];
      end
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid  = 1'b0;
      next_st.rsp.awready = 1'b1;
      next_st.rsp.wready  = 1'b1;
    end

    // reads answer one cycle after the address is taken
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid  = 1'b1;
      next_st.rsp.rdata   = '0;
      next_st.rsp.rresp   = (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (rd_reg != REG_NONE) begin
        next_st.rsp.rdata[PSEL_MSB:PSEL_LSB] = st.psel[rd_reg];
        next_st.rsp.rdata[IRQ_INPUT_ENABLE_BIT]          = st.irq_input_enable[rd_reg];
      end
    end else if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid  = 1'b0;
      next_st.rsp.arready = 1'b1;
    end

    // pin routing; the pin side is registered, so routes lag one cycle
    next_st.func_i = '0;
    for (int p = 0; p < NPIN; p++) begin
      f = route(4'(p), st.psel[p]);
      if (f == F_NONE) begin
        next_st.pin_out[p] = 1'b0;
        next_st.pin_oe[p]  = 1'b0;
      end else begin
        next_st.pin_out[p] = func_o[f];
        next_st.pin_oe[p]  = func_oe[f];
        next_st.func_i[f]  = next_st.func_i[f] | pin_in[p];
      end
    end

    // interrupt steering, independent of the peripheral selection
    next_st.irq[IRQ2_BIT] = ien[PIN_B1] | ien[PIN_D4];
    next_st.irq[IRQ3_BIT] = ien[PIN_B4] | ien[PIN_D5];
    next_st.irq[IRQ4_BIT] = ien[PIN_A2];
    next_st.irq[IRQ5_BIT] = ien[PIN_B7] | ien[PIN_D6];
  end

  // state register; every control field has a reset constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st             <= '0;
      st.psel        <= {NPIN{PSEL_RESET}};
      st.irq_input_enable        <= {NPIN{IRQ_INPUT_ENABLE_RESET}};
      st.rsp.awready <= 1'b1;
      st.rsp.wready  <= 1'b1;
      st.rsp.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp                    = st.rsp;
  assign pin_out                    = st.pin_out;
  assign pin_oe                     = st.pin_oe;
  assign func_i                     = st.func_i;
  assign external_interrupt_request = st.irq;

  // helper: registers not addressed by the write in flight
  logic [NPIN-1:0]      untouched;
  logic [NPIN-1:0][4:0] keep_mask;
  always_comb begin
    untouched = '1;
    if (wr_reg != REG_NONE) untouched[wr_reg] = 1'b0;
    // one mask bit per selection bit, so each mask slice lines up with its pin
    for (int i = 0; i < NPIN; i++) keep_mask[i] = {5{untouched[i]}};
  end

  a_reserved_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    st.rsp.rvalid |-> (st.rsp.rdata[7] == 1'b0 && st.rsp.rdata[5] == 1'b0))
    else $error("reserved bits read nonzero");

  a_reset_idle_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> (st.psel == '0 && st.pin_oe == '0 && st.irq == '0))
    else $error("pins not idle after reset");

  a_write_stores_field: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_reg != REG_NONE && st.wstrb[0]) |=>
      st.psel[$past(wr_reg)] == $past(st.wdata[4:0]))
    else $error("selection field not written");

  a_write_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> ((st.psel & $past(keep_mask)) == ($past(st.psel) & $past(keep_mask))) &&
                 ((st.irq_input_enable & $past(untouched)) == ($past(st.irq_input_enable) & $past(untouched))))
    else $error("write disturbed another pin");

  a_irq4_port_a2: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 external_interrupt_request[IRQ4_BIT] == $past(st.irq_input_enable[PIN_A2] & pin_in[PIN_A2]))
    else $error("request 4 not steered from port A pin 2");

  a_irq_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.irq_input_enable == '0) |=> (external_interrupt_request == '0))
    else $error("request raised with input enables clear");

  a_irq5_port_d6: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.irq_input_enable[PIN_D6] && !st.irq_input_enable[PIN_B7] && pin_in[PIN_D6]) |=>
      external_interrupt_request[IRQ5_BIT])
    else $error("request 5 missed from port D pin 6");

  a_timer1_a2_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.psel[PIN_A2] == SEL_TIMER) |=>
      (pin_out[PIN_A2] == $past(func_o[F_TIMER1_IO_A]) &&
       pin_oe[PIN_A2] == $past(func_oe[F_TIMER1_IO_A])))
    else $error("timer1 A not on port A pin 2");

  a_i2c_clock_in: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.psel[PIN_B1] == SEL_I2C) |=> func_i[F_I2C0_CLOCK_LINE] == $past(pin_in[PIN_B1]))
    else $error("i2c clock input not from port B pin 1");

  a_adc_status_d6: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.psel[PIN_D6] == SEL_ADC) |=> pin_oe[PIN_D6] == $past(func_oe[F_ADC_CONVERSION_STATUS]))
    else $error("adc status not on port D pin 6");

  a_unlisted_code_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.psel[PIN_B4] != SEL_CONTROL) |=> (!pin_oe[PIN_B4] && !pin_out[PIN_B4]))
    else $error("disallowed code drove port B pin 4");

  a_unrouted_idle: assert property (
    (st.psel == '0) |=> (pin_oe == '0 && pin_out == '0 && func_i == '0))
    else $error("unrouted pins not idle");

  // interrupt steering, one check per enabled pin
  a_irq2_port_b1: assert property (
    (st.irq_input_enable[PIN_B1] && pin_in[PIN_B1]) |=> external_interrupt_request[IRQ2_BIT])
    else $error("request 2 missed from port B pin 1");

  a_irq3_port_b4: assert property (
    (st.irq_input_enable[PIN_B4] && pin_in[PIN_B4]) |=> external_interrupt_request[IRQ3_BIT])
    else $error("request 3 missed from port B pin 4");

  a_irq5_port_b7: assert property (
    (st.irq_input_enable[PIN_B7] && pin_in[PIN_B7]) |=> external_interrupt_request[IRQ5_BIT])
    else $error("request 5 missed from port B pin 7");

  a_irq2_port_d4: assert property (
    (st.irq_input_enable[PIN_D4] && pin_in[PIN_D4]) |=> external_interrupt_request[IRQ2_BIT])
    else $error("request 2 missed from port D pin 4");

  a_irq3_port_d5: assert property (
    (st.irq_input_enable[PIN_D5] && pin_in[PIN_D5]) |=> external_interrupt_request[IRQ3_BIT])
    else $error("request 3 missed from port D pin 5");

  // one route per rule, on the output or the input side
  a_timer1_a3_route: assert property ((st.psel[PIN_A3] == SEL_TIMER) |=>
    pin_oe[PIN_A3] == $past(func_oe[F_TIMER1_IO_B]))
    else $error("timer1 B not on port A pin 3");

  a_timer2_a3_route: assert property ((st.psel[PIN_A3] == SEL_TIMER_ALT) |=>
    pin_out[PIN_A3] == $past(func_o[F_TIMER2_IO_A]))
    else $error("timer2 A not on port A pin 3");

  a_serial12_flow_a3: assert property ((st.psel[PIN_A3] == SEL_SERIAL_C) |=>
    func_i[F_SERIAL12_FLOW] == $past(pin_in[PIN_A3]))
    else $error("serial12 flow not from port A pin 3");

  a_timer0_b0_route: assert property ((st.psel[PIN_B0] == SEL_TIMER) |=>
    pin_out[PIN_B0] == $past(func_o[F_TIMER0_IO_D]))
    else $error("timer0 D not on port B pin 0");

  a_ext_clock_b7: assert property ((st.psel[PIN_B7] == SEL_EXT_CLOCK) |=>
    func_i[F_TIMER_EXT_CLOCK_D] == $past(pin_in[PIN_B7]))
    else $error("clock D not from port B pin 7");

  a_capture_w_b1: assert property ((st.psel[PIN_B1] == SEL_TIMER_ALT) |=>
    func_i[F_TIMER5_CAPTURE_W] == $past(pin_in[PIN_B1]))
    else $error("capture W not from port B pin 1");

  a_disable_req_b4: assert property ((st.psel[PIN_B4] == SEL_CONTROL) |=>
    func_i[F_OUTPUT_DISABLE_REQUEST_8] == $past(pin_in[PIN_B4]))
    else $error("disable request not from port B pin 4");

  a_adc_trigger_b5: assert property ((st.psel[PIN_B5] == SEL_ADC) |=>
    func_i[F_ADC_EXTERNAL_TRIGGER] == $past(pin_in[PIN_B5]))
    else $error("adc trigger not from port B pin 5");

  a_serial5_clock_b3: assert property ((st.psel[PIN_B3] == SEL_SERIAL_A) |=>
    pin_oe[PIN_B3] == $past(func_oe[F_SERIAL5_CLOCK]))
    else $error("serial5 clock not on port B pin 3");

  a_serial1_tx_b6: assert property ((st.psel[PIN_B6] == SEL_SERIAL_B) |=>
    pin_out[PIN_B6] == $past(func_o[F_SERIAL1_TRANSMIT]))
    else $error("serial1 transmit not on port B pin 6");

  a_serial12_tx_b0: assert property ((st.psel[PIN_B0] == SEL_SERIAL_C) |=>
    pin_oe[PIN_B0] == $past(func_oe[F_SERIAL12_TRANSMIT]))
    else $error("serial12 transmit not on port B pin 0");

  a_i2c_data_b2: assert property ((st.psel[PIN_B2] == SEL_I2C) |=>
    pin_oe[PIN_B2] == $past(func_oe[F_I2C0_DATA_LINE]))
    else $error("i2c data not on port B pin 2");

  a_timer0_d3_route: assert property ((st.psel[PIN_D3] == SEL_TIMER) |=>
    pin_out[PIN_D3] == $past(func_o[F_TIMER0_IO_A]))
    else $error("timer0 A not on port D pin 3");

  a_serial1_clock_d4: assert property ((st.psel[PIN_D4] == SEL_SERIAL_A) |=>
    pin_oe[PIN_D4] == $past(func_oe[F_SERIAL1_CLOCK]))
    else $error("serial1 clock not on port D pin 4");

  a_read_answer: assert property (
    (axi_req.arvalid && st.rsp.arready) |=> st.rsp.rvalid)
    else $error("read answer late");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.aw_held && st.w_held) |-> ##[0:1] st.rsp.bvalid)
    else $error("write response late");

  c_write_slverr: cover property (@(posedge aclk) disable iff (!aresetn)
    st.rsp.bvalid && st.rsp.bresp == RESP_SLVERR);
  c_read_ok: cover property (@(posedge aclk) disable iff (!aresetn)
    st.rsp.rvalid && st.rsp.rresp == RESP_OKAY && st.rsp.rdata != '0);
  c_serial5_route: cover property (@(posedge aclk) disable iff (!aresetn)
    st.psel[PIN_B2] == SEL_SERIAL_A && pin_oe[PIN_B2]);
  c_irq2_raise: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(external_interrupt_request[IRQ2_BIT]));
  c_read_slverr: cover property (@(posedge aclk) disable iff (!aresetn)
    st.rsp.rvalid && st.rsp.rresp == RESP_SLVERR);

endmodule : port_pin_function_selector

// ===== verif/peripheral_far_side.sv
`timescale 1ns/1ps
// stands in for the timers, serial units and package pins behind the selector
module peripheral_far_side
  import pin_function_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic [NPIN-1:0]  pin_out,
  input  wire logic [NPIN-1:0]  pin_oe,
  output logic      [NFUNC-1:0] func_o,
  output logic      [NFUNC-1:0] func_oe,
  output logic      [NPIN-1:0]  pin_in
);
  int              seed = 32'h3fc5;
  logic [NPIN-1:0] ext_level;

  initial begin
    func_o    = '0;
    func_oe   = '0;
    ext_level = '0;
  end

  // fresh values every cycle, so a stale or wrong route cannot match for long
  always @(posedge aclk) begin
    func_o    <= NFUNC'({$random(seed), $random(seed)});
    func_oe   <= NFUNC'({$random(seed), $random(seed)});
    ext_level <= NPIN'($random(seed));
  end

  // pin level: the selector wins where it drives, the outside world elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : peripheral_far_side

// ===== verif/port_pin_function_selector_tb.sv
`timescale 1ns/1ps
module port_pin_function_selector_tb;
  import pin_function_pkg::*;
  logic             aclk    = 1'b0;
  logic             aresetn = 1'b0;
  axi_req_s         req;
  axi_rsp_s         rsp;
  logic [NPIN-1:0]  pin_in, pin_out, pin_oe;
  logic [NFUNC-1:0] func_o, func_oe, func_i;
  logic [NIRQ-1:0]  irq;
  logic [1:0]       wq[$];
  logic [33:0]      rq[$];
  int               bad_count = 0;
  int               n_tests   = 0;
  logic [3:0]       p;
  logic [5:0]       f;
  logic [31:0]      d;
  logic             fo, foe, pi;
  // each entry: pin slot, selection code, function slot
  logic [19:0] route_tab [43] = '{20'h00104, 20'h10105, 20'h00307, 20'h10306, 20'h00a14,
    20'h10c1c, 20'h20103, 20'h30102, 20'h40101, 20'h50100, 20'h80105, 20'h90109, 20'h2020c,
    20'h3020b, 20'h4020d, 20'h9020e, 20'h20306, 20'h3030a, 20'h80308, 20'h5070f, 20'h60710,
    20'h40911, 20'h70912, 20'h30a15, 20'h90a15, 20'h40a16, 20'h80a16, 20'h50a17, 20'h80b18,
    20'h90b19, 20'h20c1d, 20'h50c1e, 20'h30f1f, 20'h40f20, 20'ha0100, 20'hb0101, 20'hc0102,
    20'hd0103, 20'hd0913, 20'ha0a18, 20'hb0a1a, 20'hc0a19, 20'hd0a1b};
  // each entry: pin slot, interrupt line bit
  logic [7:0]  irq_tab [7] = '{8'h02, 8'h30, 8'h61, 8'h93, 8'hb0, 8'hc1, 8'hd3};

  always #50 aclk = ~aclk;

  port_pin_function_selector uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .func_o(func_o),
    .func_oe(func_oe), .func_i(func_i), .external_interrupt_request(irq));
  peripheral_far_side far_side (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .func_o(func_o), .func_oe(func_oe), .pin_in(pin_in));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // a silent slave must not hang the run
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      bad_count++;
      $display("[FAIL] bus answer expected within 200 cycles seen none");
      report_and_stop();
    end
  endtask : guard

  function automatic logic [31:0] adr(input logic [3:0] s);
    return {REG_INDEX[s][29:0], 2'b00};
  endfunction : adr

  // readies are registered, so the level seen at the falling edge holds at the next rise
  task automatic axi_write(input logic [31:0] a, input logic [31:0] wd, input logic [1:0] er);
    int   n;
    logic aw_done, w_done, aw_hs, w_hs;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    wq.push_back(er);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= wd;
    req.wstrb   <= 4'hf;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hs = req.awvalid && rsp.awready;
      w_hs = req.wvalid && rsp.wready;
      guard(n);
      @(posedge aclk);
      if (aw_hs) begin
        req.awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hs) begin
        req.wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do begin @(negedge aclk); guard(n); end while (!rsp.bvalid);
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do begin @(negedge aclk); guard(n); end while (!rsp.arready);
    @(posedge aclk);
    req.arvalid <= 1'b0;
    do begin @(negedge aclk); guard(n); end while (!rsp.rvalid);
    @(posedge aclk);
  endtask : axi_read

  // result watcher: each answer seen before its accepting edge takes the oldest note
  always @(negedge aclk) begin
    if (rsp.bvalid && req.bready && wq.size() > 0) begin
      chk("write response", {32'h0, wq.pop_front()}, {32'h0, rsp.bresp});
    end
    if (rsp.rvalid && req.rready && rq.size() > 0) begin
      chk("read response", rq.pop_front(), {rsp.rresp, rsp.rdata});
    end
  end

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NPIN; i++) axi_read(adr(4'(i)), {RESP_OKAY, 32'h0});
    $display("test reset values done");
    foreach (route_tab[i]) begin
      p = route_tab[i][19:16];
      f = route_tab[i][5:0];
      d = {25'h0, i[0], 1'b0, route_tab[i][12:8]};
      axi_write(adr(p), d, RESP_OKAY);
      axi_read(adr(p), {RESP_OKAY, d});
      @(negedge aclk);
      fo = func_o[f];
      foe = func_oe[f];
      pi = pin_in[p];
      @(negedge aclk);
      chk("pin enable", {33'h0, foe}, {33'h0, pin_oe[p]});
      chk("pin value", {33'h0, fo}, {33'h0, pin_out[p]});
      chk("func input", {33'h0, pi}, {33'h0, func_i[f]});
      axi_write(adr(p), 32'h0, RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk("pin released", 34'h0, {33'h0, pin_oe[p]});
      chk("input released", 34'h0, {33'h0, func_i[f]});
    end
    $display("test routes done");
    foreach (irq_tab[i]) begin
      p = irq_tab[i][7:4];
      axi_write(adr(p), 32'h40, RESP_OKAY);
      axi_read(adr(p ^ 4'h1), {RESP_OKAY, 32'h0});
      @(negedge aclk);
      pi = pin_in[p];
      @(negedge aclk);
      chk("irq line", {33'h0, pi}, {33'h0, irq[irq_tab[i][1:0]]});
      axi_write(adr(p), 32'h0, RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk("irq masked", 34'h0, {30'h0, irq});
    end
    $display("test interrupt steering done");
    axi_read(32'h00230650, {RESP_SLVERR, 32'h0});
    axi_write(32'h00230650, 32'h1, RESP_SLVERR);
    axi_write(adr(4'h0) + 32'h1, 32'h1, RESP_SLVERR);
    axi_read(adr(4'h0), {RESP_OKAY, 32'h0});
    $display("test unmapped access done");
    axi_write(adr(4'h5), 32'h00000047, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    chk("pins idle in reset", 34'h0, {20'h0, pin_oe});
    chk("irq idle in reset", 34'h0, {30'h0, irq});
    aresetn <= 1'b1;
    axi_read(adr(4'h5), {RESP_OKAY, 32'h0});
    $display("test second reset done");
    report_and_stop();
  end
endmodule : port_pin_function_selector_tb
